// >>> design/sfwb_pkg.sv
// constants, field positions and types for the subtract-with-borrow execution block
package sfwb_pkg;

  // ==========================================================================
  // clock and instruction cycle
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned QUARTERS_PER_IC = 4;

  // ==========================================================================
  // opcode layout: 0101 01da ffff ffff
  // ==========================================================================
  localparam logic [15:0] OPC_MASK       = 16'hfc00;
  localparam logic [15:0] OPC_MATCH      = 16'h5400;
  localparam int unsigned DEST_BIT       = 9;
  localparam int unsigned BANK_BIT       = 8;
  localparam int unsigned FILE_LSB       = 0;
  localparam int unsigned FILE_W         = 8;

  // ==========================================================================
  // address resolution
  // ==========================================================================
  localparam logic [7:0]  INDEXED_MAX    = 8'h5f;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;

  // ==========================================================================
  // apb register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_INSTR      = 8'h04;
  localparam logic [7:0]  OFS_WORK       = 8'h08;
  localparam logic [7:0]  OFS_STATUS     = 8'h0c;
  localparam logic [7:0]  OFS_BANK       = 8'h10;
  localparam logic [7:0]  OFS_INDEX      = 8'h14;
  localparam logic [7:0]  OFS_INFO       = 8'h18;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int unsigned CTRL_EXT_BIT   = 0;
  localparam int unsigned ST_C           = 0;
  localparam int unsigned ST_DC          = 1;
  localparam int unsigned ST_Z           = 2;
  localparam int unsigned ST_OV          = 3;
  localparam int unsigned ST_N           = 4;
  localparam int unsigned INFO_BUSY_BIT  = 0;
  localparam int unsigned INFO_ILL_BIT   = 1;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic        EXT_RST        = 1'b0;
  localparam logic [15:0] OPCODE_RST     = 16'h0000;
  localparam logic [7:0]  WORK_RST       = 8'h00;
  localparam logic [4:0]  STATUS_RST     = 5'h00;
  localparam logic [3:0]  BANK_RST       = 4'h0;
  localparam logic [11:0] INDEX_RST      = 12'h000;

  // ==========================================================================
  // quarter-cycle phases
  // ==========================================================================
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1   = 3'b001,
    PH_Q2   = 3'b011,
    PH_Q3   = 3'b010,
    PH_Q4   = 3'b110
  } sfwb_phase_t;

endpackage

// >>> design/sfwb_alu_if.sv
// operand and result bundle between the core sequencer and the subtractor
`timescale 1ns/10ps
interface sfwb_alu_if;
  logic [7:0] work;
  logic [7:0] file;
  logic       carry_in;
  logic [7:0] result;
  logic       c_out;
  logic       dc_out;
  logic       z_out;
  logic       ov_out;
  logic       n_out;

  modport core (output work, file, carry_in,
                input  result, c_out, dc_out, z_out, ov_out, n_out);
  modport alu  (input  work, file, carry_in,
                output result, c_out, dc_out, z_out, ov_out, n_out);
endinterface

// >>> design/sfwb_sub_alu.sv
// two's complement subtractor: work minus file minus inverted carry
`timescale 1ns/10ps
module sfwb_sub_alu
  import sfwb_pkg::*;
(
  // operands and results
  sfwb_alu_if.alu a
);

  logic [8:0] sum;
  logic [4:0] low;

  // ==========================================================================
  // w + ~f + c equals w - f - (not c)
  // ==========================================================================
  always_comb begin
    sum = {1'b0, a.work} + {1'b0, ~a.file} + {8'h00, a.carry_in};
    low = {1'b0, a.work[3:0]} + {1'b0, ~a.file[3:0]} + {4'h0, a.carry_in};
  end

  assign a.result = sum[7:0];
  assign a.c_out  = sum[8];
  assign a.dc_out = low[4];
  assign a.z_out  = (sum[7:0] == 8'h00);
  assign a.n_out  = sum[7];
  assign a.ov_out = (a.work[7] != a.file[7]) && (sum[7] != a.work[7]);

endmodule

// >>> design/sfwb_core.sv
// execution unit for subtract_file_from_work_borrow with apb register access
//
// Overview of operation
// - result is work minus file minus borrow
// - destination clear: result goes to work
// - destination set: result written to file
// - bank clear, no extension: use access bank
// - bank set: bank_select_reg plus file field
// - extended, bank clear, f<=5Fh: indexed offset
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
module sfwb_core
  import sfwb_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // file memory port
  output logic      [11:0] file_addr,
  output logic             file_re,
  output logic             file_we,
  output logic      [7:0]  file_wdata,
  input  wire logic [7:0]  file_rdata,
  // execution state
  output logic             busy
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    sfwb_phase_t phase;
    logic [15:0] opcode;
    logic        ext_en;
    logic [7:0]  work;
    logic [4:0]  status;
    logic [3:0]  bank;
    logic [11:0] index_base;
    logic [7:0]  operand;
    logic [7:0]  result;
    logic [4:0]  flags;
    logic        illegal;
    logic [11:0] faddr;
    logic [7:0]  fwdata;
    logic        fwe;
    logic        fre;
    logic        busy;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sfwb_state_t;

  localparam sfwb_state_t STATE_RST = '{
    phase:      PH_IDLE,
    opcode:     OPCODE_RST,
    ext_en:     EXT_RST,
    work:       WORK_RST,
    status:     STATUS_RST,
    bank:       BANK_RST,
    index_base: INDEX_RST,
    operand:    8'h00,
    result:     8'h00,
    flags:      5'h00,
    illegal:    1'b0,
    faddr:      12'h000,
    fwdata:     8'h00,
    fwe:        1'b0,
    fre:        1'b0,
    busy:       1'b0,
    prdata:     32'h0000_0000,
    pready:     1'b0,
    pslverr:    1'b0
  };

  sfwb_state_t q;
  sfwb_state_t d;

  sfwb_alu_if alu_bus ();

  // ==========================================================================
  // subtractor
  // ==========================================================================
  sfwb_sub_alu u_alu (
    .a (alu_bus.alu)
  );

  assign alu_bus.work     = q.work;
  assign alu_bus.file     = q.operand;
  assign alu_bus.carry_in = q.status[ST_C];

  // ==========================================================================
  // helpers
  // ==========================================================================
  logic        access;
  logic        commit;
  logic        mapped;
  logic        stall;
  logic [7:0]  fsel;
  logic [11:0] eff_addr;
  logic [31:0] rdata;
  logic        opc_ok;
  logic        wr_commit;
  logic        dest_file;
  logic        bank_mode;

  // ==========================================================================
  // instruction field decode
  // ==========================================================================
  assign fsel      = q.opcode[FILE_LSB +: FILE_W];
  assign dest_file = q.opcode[DEST_BIT];
  assign bank_mode = q.opcode[BANK_BIT];

  // ==========================================================================
  // file address resolution
  // ==========================================================================
  // indexed window wraps inside the 12-bit file space
  always_comb begin
    if (bank_mode) begin
      eff_addr = {q.bank, fsel};
    end else if (q.ext_en && (fsel <= INDEXED_MAX)) begin
      eff_addr = q.index_base + {4'h0, fsel};
    end else if (fsel < ACCESS_SPLIT) begin
      eff_addr = {ACCESS_LO_BANK, fsel};
    end else begin
      eff_addr = {ACCESS_HI_BANK, fsel};
    end
  end

  // ==========================================================================
  // apb decode and read mux
  // ==========================================================================
  always_comb begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL: begin
        rdata[CTRL_EXT_BIT] = q.ext_en;
      end
      OFS_INSTR: begin
        rdata[15:0] = q.opcode;
      end
      OFS_WORK: begin
        rdata[7:0] = q.work;
      end
      OFS_STATUS: begin
        rdata[4:0] = q.status;
      end
      OFS_BANK: begin
        rdata[3:0] = q.bank;
      end
      OFS_INDEX: begin
        rdata[11:0] = q.index_base;
      end
      OFS_INFO: begin
        rdata[INFO_BUSY_BIT] = q.busy;
        rdata[INFO_ILL_BIT]  = q.illegal;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // apb handshake
  // ==========================================================================
  // an instr write while executing is held off by withholding pready
  assign access    = psel && penable;
  assign commit    = access && q.pready;
  assign wr_commit = commit && pwrite && !q.pslverr;
  assign stall     = pwrite && (paddr == OFS_INSTR) && (q.phase != PH_IDLE);
  assign opc_ok    = (pwdata[15:0] & OPC_MASK) == OPC_MATCH;

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    d         = q;
    d.fwe     = 1'b0;
    d.fre     = 1'b0;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;

    // apb answer, one wait state
    if (access && !q.pready && !stall) begin
      d.pready  = 1'b1;
      d.pslverr = !mapped;
      d.prdata  = mapped ? rdata : 32'h0000_0000;
    end

    // apb writes take effect at the completing edge
    if (wr_commit) begin
      unique case (paddr)
        OFS_CTRL: begin
          d.ext_en = pwdata[CTRL_EXT_BIT];
        end
        OFS_INSTR: begin
          d.opcode = pwdata[15:0];
          if (opc_ok) begin
            d.illegal = 1'b0;
            d.phase   = PH_Q1;
            d.busy    = 1'b1;
          end else begin
            d.illegal = 1'b1;
          end
        end
        OFS_WORK: begin
          d.work = pwdata[7:0];
        end
        OFS_STATUS: begin
          d.status = pwdata[4:0];
        end
        OFS_BANK: begin
          d.bank = pwdata[3:0];
        end
        OFS_INDEX: begin
          d.index_base = pwdata[11:0];
        end
        OFS_INFO: begin
          d.illegal = q.illegal;
        end
        default: begin
          d.illegal = q.illegal;
        end
      endcase
    end

    // quarter-cycle sequencer: decode, read, process, write
    unique case (q.phase)
      PH_IDLE: begin
        d.busy = d.busy;
      end
      PH_Q1: begin
        d.faddr = eff_addr;
        d.fre   = 1'b1;
        d.phase = PH_Q2;
      end
      PH_Q2: begin
        // file_rdata follows file_addr while the read pulse is high
        d.operand = file_rdata;
        d.phase   = PH_Q3;
      end
      PH_Q3: begin
        d.result = alu_bus.result;
        d.flags[ST_C]  = alu_bus.c_out;
        d.flags[ST_DC] = alu_bus.dc_out;
        d.flags[ST_Z]  = alu_bus.z_out;
        d.flags[ST_OV] = alu_bus.ov_out;
        d.flags[ST_N]  = alu_bus.n_out;
        d.phase  = PH_Q4;
      end
      PH_Q4: begin
        // coming last, this wins over a software write in the same cycle
        if (dest_file) begin
          d.fwe    = 1'b1;
          d.fwdata = q.result;
        end else begin
          d.work = q.result;
        end
        d.status = q.flags;
        d.phase  = PH_IDLE;
        d.busy   = 1'b0;
      end
      default: begin
        d.phase = PH_IDLE;
        d.busy  = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign prdata     = q.prdata;
  assign pready     = q.pready;
  assign pslverr    = q.pslverr;
  assign file_addr  = q.faddr;
  assign file_re    = q.fre;
  assign file_we    = q.fwe;
  assign file_wdata = q.fwdata;
  assign busy       = q.busy;

endmodule

// >>> test/sfwb_core_properties.sv
// assertion checker for the subtract-with-borrow execution block
`timescale 1ns/10ps
module sfwb_core_properties
  import sfwb_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // execution
  input wire logic        file_re,
  input wire logic        file_we,
  input wire logic        busy
);
  // ========
  // helpers
  logic cmt;
  logic legal;
  assign cmt   = psel && penable && pready && pwrite && paddr == OFS_INSTR;
  assign legal = (pwdata[15:0] & OPC_MASK) == OPC_MATCH;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ========
  // properties
  AST_START: assert property (cmt && legal |=> busy ##1 file_re)
    else $error("legal opcode did not start");
  AST_ONE_IC: assert property ($rose(busy) |-> busy [*4] ##1 !busy)
    else $error("execution length wrong");
  AST_ILLEGAL: assert property (cmt && !legal |=> !busy)
    else $error("illegal opcode executed");
  AST_RE_BUSY: assert property (file_re |-> busy ##1 !file_re)
    else $error("file read outside execution");
  AST_WE_END: assert property (file_we |-> $past(busy) && !busy)
    else $error("file write at wrong time");
  AST_WE_PULSE: assert property (file_we |=> !file_we)
    else $error("file write longer than one cycle");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_UNMAPPED: assert property (pready && (paddr > OFS_INFO || paddr[1:0] != 2'h0)
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_COV_START: cover property (cmt && legal);
  AST_COV_WRITE: cover property (file_we);
  AST_COV_ERR: cover property (pslverr);
  AST_COV_STALL: cover property (psel && penable && pwrite && paddr == OFS_INSTR && busy);
endmodule

bind sfwb_core sfwb_core_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .file_re(file_re),
  .file_we(file_we), .busy(busy));

// >>> test/tb_subtract_with_borrow_exec.sv
// self-checking bench for the subtract-with-borrow execution block
`timescale 1ns/10ps
module tb_subtract_with_borrow_exec
  import sfwb_pkg::*;
;
  // ========
  // signals
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] file_addr;
  logic        file_re;
  logic        file_we;
  logic [7:0]  file_wdata;
  logic [7:0]  file_rdata;
  logic        busy;
  logic [7:0]  mem [4096];
  logic [31:0] q;
  logic        e;
  int          error_cnt;
  int          checks;
  int          cyc;
  int          i, w, fa, st, ext, bk, ix, d, a, ad, fv, s, r, ov, dc;
  int          bt [6] = '{'h5f, 'h60, 'h7f, 'h80, 0, 'hff};
  sfwb_core u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .file_addr(file_addr),
    .file_re(file_re), .file_we(file_we), .file_wdata(file_wdata),
    .file_rdata(file_rdata), .busy(busy));
  // ========
  // clock, file memory, timeout
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  assign file_rdata = mem[file_addr];
  always @(posedge pclk) begin
    if (file_we === 1'b1) mem[file_addr] <= file_wdata;
    cyc++;
    if (cyc > 10000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ========
  // tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] ad_i, input logic [31:0] dt);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad_i;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task stop_test();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ========
  // main sequence
  initial begin
    void'($urandom(23));
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    for (i = 0; i < 4096; i++) mem[i] = $urandom % 256;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 7; i++) begin
      apb(0, 8'(i * 4), 0);
      chk(q, 0);
    end
    apb(0, 8'h1c, 0);
    chk(32'(e), 32'h1);
    chk(q, 32'h0);
    apb(1, 8'h05, 32'hffff_ffff);
    chk(32'(e), 32'h1);
    apb(0, OFS_CTRL, 0);
    chk(q, 32'h0);
    apb(1, OFS_INSTR, 0);
    apb(0, OFS_INFO, 0);
    chk(q, 2);
    $display("test regs done");
    for (i = 0; i < 40; i++) begin
      w = $urandom % 256;
      st = $urandom % 32;
      ext = $urandom % 2;
      bk = $urandom % 16;
      ix = $urandom % 4096;
      d = (i < 6) ? 1 : $urandom % 2;
      a = $urandom % 2;
      fa = $urandom % 256;
      if (i < 6) begin
        fa = bt[i];
        a = 0;
        ext = i < 2;
      end
      ad = a ? bk * 256 + fa : (ext && fa <= 95) ? (ix + fa) % 4096
         : fa < 128 ? fa : 'hf00 + fa;
      fv = mem[ad];
      apb(1, OFS_CTRL, ext);
      apb(1, OFS_WORK, w);
      apb(1, OFS_STATUS, st);
      apb(1, OFS_BANK, bk);
      apb(1, OFS_INDEX, ix);
      apb(1, OFS_INSTR, 'h5400 + d * 512 + a * 256 + fa);
      apb(0, OFS_INFO, 0);
      chk(q, 1);
      while (busy !== 1'b0 && cyc < 10000) @(posedge pclk);
      s = w + (fv ^ 255) + st % 2;
      r = s % 256;
      dc = ((w % 16) + ((fv ^ 255) % 16) + st % 2) / 16;
      ov = ((w ^ fv) & (w ^ r) & 128) != 0;
      apb(0, OFS_WORK, 0);
      chk(q, d ? w : r);
      apb(0, OFS_STATUS, 0);
      chk(q, (r / 128) * 16 + ov * 8 + (r == 0) * 4 + dc * 2 + s / 256);
      chk(32'(mem[ad]), d ? r : fv);
    end
    $display("test exec loop done");
    w = $urandom % 256;
    fv = mem[5];
    apb(1, OFS_CTRL, 0);
    apb(1, OFS_WORK, w);
    apb(1, OFS_STATUS, 1);
    apb(1, OFS_INSTR, 32'h0000_5405);
    apb(1, OFS_INSTR, 32'h0000_5405);
    apb(0, OFS_INFO, 0);
    chk(q, 1);
    while (busy !== 1'b0 && cyc < 10000) @(posedge pclk);
    s = w + (fv ^ 255) + 1;
    s = s % 256 + (fv ^ 255) + s / 256;
    apb(0, OFS_WORK, 0);
    chk(q, s % 256);
    apb(0, OFS_STATUS, 0);
    chk(q & 1, s / 256);
    chk(32'(mem[5]), fv);
    apb(0, OFS_INFO, 0);
    chk(q, 0);
    $display("test exec done");
    stop_test();
  end
endmodule
